// ===== logic/dhp_pkg.sv
// constants, modes and state encodings shared by the display host bus port
`default_nettype none
package dhp_pkg;

    localparam int CLK_NS = 20;

    // parallel cycle timing, nanoseconds
    localparam int T_AS_NS = 10;
    localparam int T_PW_WR_NS = 60;
    localparam int T_PW_RD_NS = 120;
    localparam int T_ACC_NS = 140;
    localparam int T_PWH_NS = 60;
    localparam int T_CYCLE_NS = 300;
    // serial timing, nanoseconds
    localparam int T_CSS_NS = 20;
    localparam int T_CSH_NS = 10;
    localparam int T_SCLK_LO_NS = 20;
    localparam int T_SCLK_HI_NS = 200;
    // display reset pulse width, nanoseconds
    localparam int T_RES_NS = 3000;
    // two flops on the read data pins
    localparam int SYNC_LAT = 2;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam logic [7:0] C_AS = 8'(cyc_min(T_AS_NS));
    localparam logic [7:0] C_WR = 8'(cyc_min(T_PW_WR_NS));
    localparam logic [7:0] C_RD = 8'(imax(cyc_min(T_PW_RD_NS), cyc_min(T_ACC_NS)) + SYNC_LAT + 1);
    localparam logic [7:0] C_HOLD_WR = 8'(imax(cyc_min(T_PWH_NS),
        cyc_min(T_CYCLE_NS) - cyc_min(T_AS_NS) - cyc_min(T_PW_WR_NS)));
    localparam logic [7:0] C_HOLD_RD = 8'(imax(cyc_min(T_PWH_NS),
        cyc_min(T_CYCLE_NS) - cyc_min(T_AS_NS) - int'(C_RD)));
    localparam logic [7:0] C_CSS = 8'(cyc_min(T_CSS_NS));
    localparam logic [7:0] C_CSH = 8'(cyc_min(T_CSH_NS));
    localparam logic [7:0] C_SLO = 8'(cyc_min(T_SCLK_LO_NS));
    localparam logic [7:0] C_SHI = 8'(cyc_min(T_SCLK_HI_NS));
    localparam logic [7:0] C_RES = 8'(cyc_min(T_RES_NS));

    // request word layout in the FIFO
    localparam int REQ_W = 10;
    localparam int REQ_RD_BIT = 9;
    localparam int REQ_DC_BIT = 8;
    localparam int FIFO_DEPTH = 4;

    // data bus pin roles
    localparam int SCLK_BIT = 0;
    localparam int SDATA_BIT = 1;
    localparam logic [7:0] OE_N_RELEASE = 8'hff;
    localparam logic [7:0] OE_N_DRIVE = 8'h00;
    localparam logic [7:0] OE_N_SERIAL = 8'h04;
    localparam logic [2:0] BIT_MSB = 3'h7;

    typedef enum logic [1:0] {
        MODE_8080 = 2'h0,
        MODE_6800 = 2'h1,
        MODE_SPI3 = 2'h2,
        MODE_SPI4 = 2'h3
    } dhp_mode_t;

    typedef enum logic [2:0] {
        ST_RST = 3'h0,
        ST_IDLE = 3'h1,
        ST_SETUP = 3'h3,
        ST_STROBE = 3'h2,
        ST_HOLD = 3'h6,
        ST_SLO = 3'h7,
        ST_SHI = 3'h5
    } dhp_state_t;

endpackage
`default_nettype wire

// ===== logic/dhp_fifo.sv
// request FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dhp_fifo
    import dhp_pkg::*;
#(
    parameter int W = REQ_W,
    parameter int D = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dhp_fifo_t;

    dhp_fifo_t q, d;
    logic full, empty;

    assign empty = (q.wp == q.rp);
    assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = q.mem[q.rp[AW-1:0]];

    always_comb begin
        d = q;
        if (i_in_valid && !full) begin
            d.mem[q.wp[AW-1:0]] = i_in_data;
            d.wp = q.wp + 1'b1;
        end
        if (i_out_ready && !empty) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // dhp_fifo
`default_nettype wire

// ===== logic/dhp_host_port.sv
// host-side controller driving a display module over its parallel or serial bus pins
// Function
// RULE_01: the port runs the bus as 8-bit 8080, 8-bit 6800, 3-wire serial or 4-wire serial, parallel bytes on an 8-bit two-way bus.
// RULE_02: in serial modes data goes on bus line 1, clock on line 0, line 2 is left open, upper lines and strobes are held low, and 3-wire holds data/command low.
// RULE_03: in 6800 mode the read/write select is low for a write and high for a read.
// RULE_04: data/command low selects the command path or status read, high selects display data.
// RULE_05: the display only honours the strobe while chip select is low.
// RULE_06: in 6800 mode every transfer is latched or completed on the falling edge of the strobe.
// RULE_07: a dummy display-data read precedes the first real one, whose data is valid only from the next read.
// RULE_08: while its reset pin is low the display initialises itself.
// RULE_09: serial modes allow writes only, no reads.
// RULE_10: the display drives the bus only during an addressed read.
`timescale 1ns/100ps
`default_nettype none
module dhp_host_port
    import dhp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [1:0] i_mode,
    input wire logic i_disp_reset_req,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic i_req_read,
    input wire logic i_req_dc,
    input wire logic [7:0] i_req_data,
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_data,
    output logic o_rsp_err,
    output logic o_disp_rst_n,
    output logic o_cs_n,
    output logic o_dc,
    output logic o_e_rd,
    output logic o_rw_wr,
    output logic [7:0] o_db_out,
    output logic [7:0] o_db_oe_n,
    input wire logic [7:0] i_db_in
);

    typedef struct packed {
        dhp_state_t st;
        logic [7:0] cnt;
        logic [2:0] bits;
        dhp_mode_t mode;
        logic rd;
        logic dc;
        logic [7:0] shreg;
        logic dummy;
        logic need_dummy;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_err;
        logic [7:0] db_s1;
        logic [7:0] db_s2;
        logic rst_n;
        logic cs_n;
        logic dc_pin;
        logic e_rd;
        logic rw_wr;
        logic [7:0] db_out;
        logic [7:0] oe_n;
    } dhp_host_t;

    dhp_host_t q, d;
    logic fifo_valid;
    logic fifo_pop;
    logic [REQ_W-1:0] fifo_word;

    function automatic logic is_serial(input dhp_mode_t m);
        return (m == MODE_SPI3) || (m == MODE_SPI4);
    endfunction

    // resting level of the read strobe / write strobe pins for a mode
    function automatic logic strobe_idle(input dhp_mode_t m);
        return (m == MODE_8080);
    endfunction

    function automatic logic [7:0] oe_idle(input dhp_mode_t m);
        return is_serial(m) ? OE_N_SERIAL : OE_N_RELEASE;
    endfunction

    dhp_fifo #(
        .W(REQ_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_req_valid),
        .o_in_ready(o_req_ready),
        .i_in_data({i_req_read, i_req_dc, i_req_data}),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_word)
    );

    always_comb begin
        d = q;
        fifo_pop = 1'b0;
        d.rsp_valid = 1'b0;
        d.db_s1 = i_db_in;
        d.db_s2 = q.db_s1;
        case (q.st)
            ST_RST: begin
                d.mode = dhp_mode_t'(i_mode);
                d.cs_n = 1'b1;
                d.e_rd = strobe_idle(dhp_mode_t'(i_mode)); // [RULE_02]
                d.rw_wr = strobe_idle(dhp_mode_t'(i_mode));
                d.oe_n = oe_idle(dhp_mode_t'(i_mode));
                d.db_out = '0;
                if (q.cnt == '0) begin
                    d.rst_n = 1'b1;
                    d.st = ST_IDLE;
                end else begin
                    d.rst_n = 1'b0; // [RULE_08]
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_IDLE: begin
                if (i_disp_reset_req) begin
                    d.st = ST_RST;
                    d.cnt = C_RES - 1'b1;
                    d.rst_n = 1'b0; // [RULE_08]
                    d.need_dummy = 1'b1;
                end else if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    d.mode = dhp_mode_t'(i_mode);
                    d.rd = fifo_word[REQ_RD_BIT];
                    d.dc = fifo_word[REQ_DC_BIT];
                    d.shreg = fifo_word[7:0];
                    if (fifo_word[REQ_RD_BIT] && is_serial(dhp_mode_t'(i_mode))) begin
                        // reads are refused on the serial bus
                        d.rsp_valid = 1'b1; // [RULE_09]
                        d.rsp_err = 1'b1;
                        d.rsp_data = '0;
                    end else begin
                        d.dummy = fifo_word[REQ_RD_BIT] && fifo_word[REQ_DC_BIT] && q.need_dummy; // [RULE_07]
                        if (!fifo_word[REQ_RD_BIT]) begin
                            d.need_dummy = 1'b1; // [RULE_07]
                        end
                        d.st = ST_SETUP;
                        d.cs_n = 1'b0; // [RULE_05]
                        d.dc_pin = (i_mode == MODE_SPI3) ? 1'b0 : fifo_word[REQ_DC_BIT]; // [RULE_04] [RULE_02]
                        if (is_serial(dhp_mode_t'(i_mode))) begin
                            d.cnt = C_CSS - 1'b1;
                            d.e_rd = 1'b0; // [RULE_02]
                            d.rw_wr = 1'b0;
                            d.oe_n = OE_N_SERIAL;
                            d.db_out = '0;
                        end else begin
                            d.cnt = C_AS - 1'b1;
                            if (i_mode == MODE_6800) begin
                                d.rw_wr = fifo_word[REQ_RD_BIT]; // [RULE_03]
                            end
                            // bus released for reads so only the display drives it
                            d.oe_n = fifo_word[REQ_RD_BIT] ? OE_N_RELEASE : OE_N_DRIVE; // [RULE_10]
                            d.db_out = fifo_word[7:0]; // [RULE_01]
                        end
                    end
                end
            end
            ST_SETUP: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else if (is_serial(q.mode)) begin
                    d.st = ST_SLO;
                    d.bits = BIT_MSB;
                    d.db_out[SDATA_BIT] = q.shreg[7]; // [RULE_02]
                    d.db_out[SCLK_BIT] = 1'b0;
                    d.cnt = C_SLO - 1'b1;
                end else begin
                    d.st = ST_STROBE;
                    d.cnt = (q.rd ? C_RD : C_WR) - 1'b1;
                    if (q.mode == MODE_6800) begin
                        d.e_rd = 1'b1;
                    end else if (q.rd) begin
                        d.e_rd = 1'b0;
                    end else begin
                        d.rw_wr = 1'b0;
                    end
                end
            end
            ST_STROBE: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else begin
                    // 6800: E falls here, 8080: the active-low strobe rises
                    d.e_rd = strobe_idle(q.mode); // [RULE_06]
                    d.rw_wr = (q.mode == MODE_6800) ? q.rw_wr : 1'b1;
                    if (q.rd) begin
                        d.rsp_data = q.db_s2;
                    end
                    d.st = ST_HOLD;
                    d.cnt = (q.rd ? C_HOLD_RD : C_HOLD_WR) - 1'b1;
                end
            end
            ST_HOLD: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else if (q.dummy) begin
                    // dummy read done: the real read follows under the same select
                    d.dummy = 1'b0; // [RULE_07]
                    d.st = ST_SETUP;
                    d.cnt = C_AS - 1'b1;
                end else begin
                    d.st = ST_IDLE;
                    d.cs_n = 1'b1;
                    d.oe_n = oe_idle(q.mode);
                    if (q.rd) begin
                        d.rsp_valid = 1'b1;
                        d.rsp_err = 1'b0;
                        if (q.dc) begin
                            d.need_dummy = 1'b0;
                        end
                    end
                end
            end
            ST_SLO: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else begin
                    d.db_out[SCLK_BIT] = 1'b1; // [RULE_02]
                    d.st = ST_SHI;
                    d.cnt = C_SHI - 1'b1;
                end
            end
            ST_SHI: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else begin
                    d.db_out[SCLK_BIT] = 1'b0;
                    if (q.bits == '0) begin
                        d.st = ST_HOLD;
                        d.cnt = C_CSH - 1'b1;
                    end else begin
                        d.bits = q.bits - 1'b1;
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.db_out[SDATA_BIT] = q.shreg[6];
                        d.st = ST_SLO;
                        d.cnt = C_SLO - 1'b1;
                    end
                end
            end
            default: begin
                d.st = ST_RST;
                d.cnt = C_RES - 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
            q.st <= ST_RST;
            q.cnt <= C_RES - 1'b1;
            q.need_dummy <= 1'b1;
            q.cs_n <= 1'b1;
            q.oe_n <= OE_N_RELEASE;
        end else begin
            q <= d;
        end
    end

    assign o_rsp_valid = q.rsp_valid;
    assign o_rsp_data = q.rsp_data;
    assign o_rsp_err = q.rsp_err;
    assign o_disp_rst_n = q.rst_n;
    assign o_cs_n = q.cs_n;
    assign o_dc = q.dc_pin;
    assign o_e_rd = q.e_rd;
    assign o_rw_wr = q.rw_wr;
    assign o_db_out = q.db_out;
    assign o_db_oe_n = q.oe_n;
endmodule // dhp_host_port
`default_nettype wire

// ===== tb/dhp_host_port_asserts.sv
// checker on the host port's bus pins and answers
`timescale 1ns/100ps
`default_nettype none
module dhp_host_port_asserts
    import dhp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [1:0] i_mode,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_err,
    input wire logic o_disp_rst_n,
    input wire logic o_cs_n,
    input wire logic o_dc,
    input wire logic o_e_rd,
    input wire logic o_rw_wr,
    input wire logic [7:0] o_db_out,
    input wire logic [7:0] o_db_oe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic [7:0] low_q;
    // cycles the display reset pin has been low
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_q <= 8'h00;
        end else begin
            low_q <= o_disp_rst_n ? 8'h00 : low_q + 8'h01;
        end
    end
    a_write_drive: assert property (!o_cs_n && i_mode == MODE_6800 && !o_rw_wr |-> o_db_oe_n == OE_N_DRIVE)
        else $error("bus not driven in write");
    a_read_release: assert property (!o_cs_n && i_mode == MODE_6800 && o_rw_wr |-> o_db_oe_n == OE_N_RELEASE)
        else $error("bus driven in read");
    a_strobe_cs: assert property (o_disp_rst_n && ((i_mode == MODE_6800 && o_e_rd)
        || (i_mode == MODE_8080 && !(o_e_rd && o_rw_wr))) |-> !o_cs_n)
        else $error("strobe without chip select");
    a_e_write: assert property ($rose(o_e_rd) && i_mode == MODE_6800 && !o_rw_wr |-> o_e_rd [*3] ##1 !o_e_rd)
        else $error("write strobe width");
    a_latch_stable: assert property ($fell(o_e_rd) && i_mode == MODE_6800 |->
        !o_cs_n && $stable(o_db_out) && $stable(o_dc))
        else $error("bus moved at strobe fall");
    a_serial_pins: assert property (!o_cs_n && i_mode[1] |-> o_db_oe_n == OE_N_SERIAL
        && o_db_out[7:2] == 6'h00 && !o_e_rd && !o_rw_wr)
        else $error("serial pin levels");
    a_spi3_dc: assert property (!o_cs_n && i_mode == MODE_SPI3 |-> !o_dc)
        else $error("dc not low in 3-wire");
    a_rsp_err: assert property (o_rsp_valid |-> o_rsp_err == i_mode[1])
        else $error("read refusal wrong");
    a_rst_width: assert property ($rose(o_disp_rst_n) |-> low_q inside {[C_RES - 8'h01:C_RES + 8'h01]})
        else $error("display reset width");
endmodule // dhp_host_port_asserts
`default_nettype wire

// ===== tb/dhp_disp_model.sv
// behavioural display module on the far side of the host bus
`timescale 1ns/100ps
`default_nettype none
module dhp_disp_model
    import dhp_pkg::*;
#(
    parameter logic [7:0] STATUS = 8'h5a
) (
    input wire logic i_clk,
    input wire logic [1:0] i_mode,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_dc,
    input wire logic i_e_rd,
    input wire logic i_rw_wr,
    input wire logic [7:0] i_db_out,
    input wire logic [7:0] i_db_oe_n,
    output logic [7:0] o_bus,
    output int o_wr_cnt,
    output logic [7:0] o_last,
    output logic o_last_dc
);
    logic [7:0] mem [8];
    logic [7:0] lat, sh, last_bus, src, byte_in;
    logic [2:0] wp, rp, bits;
    logic e_q, r_q, s_q;
    int acc = 0;
    wire logic par = !i_cs_n && !i_mode[1];
    wire logic rd_on = par && (i_mode == MODE_6800 ? i_e_rd && i_rw_wr : !i_e_rd);
    wire logic rd_end = par && (i_mode == MODE_6800 ? e_q && !i_e_rd && i_rw_wr : !e_q && i_e_rd);
    wire logic wr_end = par && (i_mode == MODE_6800 ? e_q && !i_e_rd && !i_rw_wr : !r_q && i_rw_wr);
    wire logic clk_up = !i_cs_n && i_mode[1] && !s_q && i_db_out[SCLK_BIT];
    assign byte_in = i_mode[1] ? {sh[6:0], i_db_out[SDATA_BIT]} : i_db_out;
    // data only after access time; a released line shows the inverse of its last level
    assign src = (rd_on && acc >= 6) ? (i_dc ? lat : STATUS) : ~last_bus;
    assign o_bus = (i_db_out & ~i_db_oe_n) | (src & i_db_oe_n);
    always_ff @(posedge i_clk) begin
        e_q <= i_e_rd;
        r_q <= i_rw_wr;
        s_q <= i_db_out[SCLK_BIT];
        last_bus <= o_bus;
        acc <= rd_on ? acc + 1 : 0;
        if (!i_rst_n) begin
            wp <= 3'h0;
            rp <= 3'h0;
            bits <= 3'h0;
            o_wr_cnt <= 0;
        end else begin
            if (i_cs_n) begin
                bits <= 3'h0;
            end
            if (clk_up) begin
                sh <= byte_in;
                bits <= bits + 3'h1;
            end
            if (wr_end || (clk_up && bits == 3'h7)) begin
                o_wr_cnt <= o_wr_cnt + 1;
                o_last <= byte_in;
                o_last_dc <= i_dc;
                lat <= ~lat;
                wp <= i_dc ? wp + 3'h1 : 3'h0;
                rp <= i_dc ? rp : 3'h0;
                if (i_dc) begin
                    mem[wp] <= byte_in;
                end
            end
            if (rd_end && i_dc) begin
                lat <= mem[rp];
                rp <= rp + 3'h1;
            end
        end
    end
endmodule // dhp_disp_model
`default_nettype wire

// ===== tb/dhp_host_port_bench.sv
// self-checking bench for the display host bus port
`timescale 1ns/100ps
`default_nettype none
module dhp_host_port_bench
    import dhp_pkg::*;
;
    localparam logic [7:0] STAT = 8'h5a;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [1:0] i_mode = MODE_6800;
    logic i_disp_reset_req = 1'b0;
    logic i_req_valid = 1'b0;
    logic i_req_read = 1'b0;
    logic i_req_dc = 1'b0;
    logic [7:0] i_req_data = 8'h00;
    logic [7:0] o_rsp_data, o_db_out, o_db_oe_n, bus, mlast;
    logic o_req_ready, o_rsp_valid, o_rsp_err, o_disp_rst_n, o_cs_n, o_dc, o_e_rd, o_rw_wr, mdc;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int stalls, mcnt, n;
    always #10 i_clk = ~i_clk;
    dhp_host_port dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_mode(i_mode), .i_disp_reset_req(i_disp_reset_req),
        .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_read(i_req_read), .i_req_dc(i_req_dc),
        .i_req_data(i_req_data), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_rsp_err(o_rsp_err),
        .o_disp_rst_n(o_disp_rst_n), .o_cs_n(o_cs_n), .o_dc(o_dc), .o_e_rd(o_e_rd), .o_rw_wr(o_rw_wr),
        .o_db_out(o_db_out), .o_db_oe_n(o_db_oe_n), .i_db_in(bus));
    dhp_disp_model #(.STATUS(STAT)) mdl_u (.i_clk(i_clk), .i_mode(i_mode), .i_rst_n(o_disp_rst_n), .i_cs_n(o_cs_n),
        .i_dc(o_dc), .i_e_rd(o_e_rd), .i_rw_wr(o_rw_wr), .i_db_out(o_db_out), .i_db_oe_n(o_db_oe_n),
        .o_bus(bus), .o_wr_cnt(mcnt), .o_last(mlast), .o_last_dc(mdc));
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic check(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic reboot(input logic [1:0] m);
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        i_mode <= m;
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
    endtask
    // request held until taken; caller drops valid with stop
    task automatic push(input logic rd, input logic dc, input logic [7:0] d);
        i_req_valid <= 1'b1;
        i_req_read <= rd;
        i_req_dc <= dc;
        i_req_data <= d;
        @(posedge i_clk);
        while (o_req_ready !== 1'b1) begin
            stalls++;
            @(posedge i_clk);
        end
    endtask
    task automatic stop();
        i_req_valid <= 1'b0;
    endtask
    task automatic wr_wait(input int w);
        for (n = 0; n < 3000 && mcnt != w; n++) @(posedge i_clk);
        check(mcnt == w, "write count");
    endtask
    task automatic rd(input logic dc, input logic [7:0] exp, input logic err);
        push(1'b1, dc, 8'h00);
        stop();
        for (n = 0; n < 500 && o_rsp_valid !== 1'b1; n++) @(posedge i_clk);
        check(o_rsp_valid === 1'b1 && o_rsp_data === exp && o_rsp_err === err, "read answer");
        @(posedge i_clk);
    endtask
    task automatic pulse_len();
        for (n = 0; n < 400 && o_disp_rst_n !== 1'b1; n++) @(posedge i_clk);
        check(n >= C_RES - 3 && n <= C_RES + 2, "display reset width");
    endtask
    task automatic t_rst();
        reboot(MODE_6800);
        pulse_len();
        i_disp_reset_req <= 1'b1;
        for (n = 0; n < 20 && o_disp_rst_n !== 1'b0; n++) @(posedge i_clk);
        i_disp_reset_req <= 1'b0;
        check(o_disp_rst_n === 1'b0, "reset request ignored");
        pulse_len();
        $display("test reset done");
    endtask
    task automatic t_par(input logic [1:0] m);
        reboot(m);
        stalls = 0;
        push(1'b0, 1'b0, 8'h15);
        push(1'b0, 1'b1, 8'ha5);
        push(1'b0, 1'b1, 8'h3c);
        push(1'b0, 1'b1, 8'h0f);
        push(1'b0, 1'b1, 8'hf0);
        stop();
        check(stalls > 0, "queue never full");
        wr_wait(5);
        check(mlast === 8'hf0 && mdc === 1'b1, "write byte");
        rd(1'b0, STAT, 1'b0);
        rd(1'b1, 8'ha5, 1'b0);
        rd(1'b1, 8'h3c, 1'b0);
        $display("test parallel mode %0d done", m);
    endtask
    task automatic t_ser(input logic [1:0] m);
        reboot(m);
        push(1'b0, 1'b1, 8'hc3);
        stop();
        wr_wait(1);
        check(mlast === 8'hc3 && mdc === (m == MODE_SPI4), "serial byte");
        rd(1'b1, 8'h00, 1'b1);
        $display("test serial mode %0d done", m);
    endtask
    initial begin
        t_rst();
        t_par(MODE_6800);
        t_par(MODE_8080);
        t_ser(MODE_SPI3);
        t_ser(MODE_SPI4);
        summarize();
    end
endmodule // dhp_host_port_bench
bind dhp_host_port dhp_host_port_asserts chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_mode(i_mode),
    .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err), .o_disp_rst_n(o_disp_rst_n), .o_cs_n(o_cs_n),
    .o_dc(o_dc), .o_e_rd(o_e_rd), .o_rw_wr(o_rw_wr), .o_db_out(o_db_out), .o_db_oe_n(o_db_oe_n));
`default_nettype wire
